// file: inc/arm_pkg.sv
// ARP rule matcher package: register map, field positions, modes.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
package arm_pkg;
  typedef enum logic [1:0] {IPM_ANY, IPM_HOST, IPM_NET} arm_ipm_e;
  typedef enum logic [1:0] {TRI_ZERO, TRI_ONE, TRI_ANY} arm_tri_e;

  localparam int          ADDR_W    = 8;
  localparam logic [7:0]  OFS_CTRL  = 8'h00;
  localparam logic [7:0]  OFS_SIPA  = 8'h04;
  localparam logic [7:0]  OFS_SIPM  = 8'h08;
  localparam logic [7:0]  OFS_TIPA  = 8'h0c;
  localparam logic [7:0]  OFS_TIPM  = 8'h10;
  localparam logic [7:0]  OFS_STAT  = 8'h14;
  localparam logic [7:0]  OFS_COUNT = 8'h18;

  localparam int          F_EN      = 0;
  localparam int          F_SIP     = 2;
  localparam int          F_TIP     = 4;
  localparam int          F_SHA     = 6;
  localparam int          F_THA     = 8;
  localparam int          F_LEN     = 10;
  localparam int          F_HRD     = 12;
  localparam int          F_PRO     = 14;

  localparam logic [31:0] CTRL_RST  = 32'h0000aa80;
  localparam logic [31:0] ADDR_RST  = 32'h00000000;
  localparam logic [31:0] MASK_RST  = 32'hffffffff;
  localparam logic [31:0] CNT_RST   = 32'h00000000;

  localparam logic [7:0]  HLN_ETH   = 8'h06;
  localparam logic [7:0]  PLN_IPV4  = 8'h04;
  localparam logic [15:0] HRD_ETH   = 16'h0001;
  localparam logic [15:0] PRO_IP    = 16'h0800;

  localparam logic [1:0]  RESP_OK   = 2'h0;
  localparam logic [1:0]  RESP_DEC  = 2'h3;
endpackage

// file: inc/arm_ip_if.sv
// Carrier between the matcher top and one protocol address criterion.
// Assumes arm_pkg is compiled first.
`timescale 1ns/100ps
`default_nettype none
interface arm_ip_if;
  arm_pkg::arm_ipm_e mode;
  logic [31:0]       cfg_addr;
  logic [31:0]       cfg_mask;
  logic [31:0]       frm_addr;
  logic              ok;
  modport cfg  (output mode, output cfg_addr, output cfg_mask, output frm_addr, input ok);
  modport crit (input mode, input cfg_addr, input cfg_mask, input frm_addr, output ok);
endinterface
`default_nettype wire

// file: rtl/arm_ip_crit.sv
// Protocol address criterion: any, host or network under mask.
// Assumes a settled configuration; purely combinational.
`timescale 1ns/100ps
`default_nettype none
module arm_ip_crit (
  arm_ip_if.crit ipc
);
  wire logic exact_eq;
  wire logic masked_eq;
  wire logic is_host;
  wire logic is_net;

  assign exact_eq  = ipc.frm_addr == ipc.cfg_addr;
  assign masked_eq = ((ipc.frm_addr ^ ipc.cfg_addr) & ipc.cfg_mask) == 32'h00000000;
  assign is_host   = ipc.mode == arm_pkg::IPM_HOST;
  assign is_net    = ipc.mode == arm_pkg::IPM_NET;
  // Unused code 3 behaves as any
  assign ipc.ok    = is_host ? exact_eq : (is_net ? masked_eq : 1'b1);
endmodule // arm_ip_crit
`default_nettype wire

// file: rtl/arm_tri_crit.sv
// Three-way criterion: condition false, condition true, or don't care.
// Assumes sel coded as arm_pkg::arm_tri_e; code 3 acts as any.
`timescale 1ns/100ps
`default_nettype none
module arm_tri_crit (
  input  wire logic [1:0] sel,
  input  wire logic       applies,
  input  wire logic       cond,
  output logic            ok
);
  wire logic is_any;

  assign is_any = sel[1];
  assign ok     = is_any | (applies & (cond == sel[0]));
endmodule // arm_tri_crit
`default_nettype wire

// file: rtl/arm_top.sv
// ARP/RARP rule entry matcher with AXI4-Lite configuration slave.
// Assumes frame fields are presented for one cycle with frm_valid.
//
// Design decisions made here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module arm_top (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic [arm_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]                 s_axi_awprot,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [arm_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]                 s_axi_arprot,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  input  wire logic                       frm_valid,
  input  wire logic                       frm_rarp,
  input  wire logic [47:0]                frame_source_mac,
  input  wire logic [47:0]                frm_sha,
  input  wire logic [47:0]                frm_tha,
  input  wire logic [31:0]                frm_spa,
  input  wire logic [31:0]                frm_tpa,
  input  wire logic [15:0]                frm_hrd,
  input  wire logic [15:0]                frm_pro,
  input  wire logic [7:0]                 frm_hln,
  input  wire logic [7:0]                 frm_pln,
  output logic                            hit_valid,
  output logic                            hit
);

  // Configuration and state registers
  logic [31:0]                ctrl_reg;
  logic [31:0]                sip_addr_reg;
  logic [31:0]                sip_mask_reg;
  logic [31:0]                tip_addr_reg;
  logic [31:0]                tip_mask_reg;
  logic [31:0]                hit_cnt_reg;
  logic                       last_hit_reg;
  logic                       seen_reg;
  logic                       hit_valid_reg;
  logic                       hit_reg;

  // Bus slave registers
  logic                       awready_reg;
  logic                       wready_reg;
  logic                       bvalid_reg;
  logic [1:0]                 bresp_reg;
  logic                       aw_held_reg;
  logic                       w_held_reg;
  logic [arm_pkg::ADDR_W-1:0] awaddr_reg;
  logic [31:0]                wdata_reg;
  logic [3:0]                 wstrb_reg;
  logic                       arready_reg;
  logic                       rvalid_reg;
  logic [31:0]                rdata_reg;
  logic [1:0]                 rresp_reg;

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i+:8] = new_v[8*i+:8];
      end
    end
    return res;
  endfunction

  // Write channel decode
  wire logic                       aw_hs;
  wire logic                       w_hs;
  wire logic                       wr_go;
  wire logic                       aw_held_next;
  wire logic                       w_held_next;
  wire logic                       bvalid_next;
  wire logic [arm_pkg::ADDR_W-1:0] wa;
  wire logic                       wr_ctrl;
  wire logic                       wr_sipa;
  wire logic                       wr_sipm;
  wire logic                       wr_tipa;
  wire logic                       wr_tipm;
  wire logic                       wr_cnt;
  wire logic                       wr_mapped;

  assign aw_hs        = s_axi_awvalid & awready_reg;
  assign w_hs         = s_axi_wvalid & wready_reg;
  assign wr_go        = aw_held_reg & w_held_reg & ~bvalid_reg;
  assign aw_held_next = aw_hs | (aw_held_reg & ~wr_go);
  assign w_held_next  = w_hs | (w_held_reg & ~wr_go);
  assign bvalid_next  = wr_go | (bvalid_reg & ~s_axi_bready);
  assign wa           = {awaddr_reg[arm_pkg::ADDR_W-1:2], 2'h0};
  assign wr_ctrl      = wr_go & (wa == arm_pkg::OFS_CTRL);
  assign wr_sipa      = wr_go & (wa == arm_pkg::OFS_SIPA);
  assign wr_sipm      = wr_go & (wa == arm_pkg::OFS_SIPM);
  assign wr_tipa      = wr_go & (wa == arm_pkg::OFS_TIPA);
  assign wr_tipm      = wr_go & (wa == arm_pkg::OFS_TIPM);
  assign wr_cnt       = wr_go & (wa == arm_pkg::OFS_COUNT);
  assign wr_mapped    = wr_ctrl | wr_sipa | wr_sipm | wr_tipa | wr_tipm | wr_cnt
                        | (wr_go & (wa == arm_pkg::OFS_STAT));

  // Read channel decode
  wire logic                       ar_hs;
  wire logic                       rvalid_next;
  wire logic [arm_pkg::ADDR_W-1:0] ra;
  logic [31:0]                     rd_data;
  logic                            rd_mapped;

  assign ar_hs       = s_axi_arvalid & arready_reg;
  assign rvalid_next = ar_hs | (rvalid_reg & ~s_axi_rready);
  assign ra          = {s_axi_araddr[arm_pkg::ADDR_W-1:2], 2'h0};

  always_comb begin
    rd_mapped = 1'b1;
    if (ra == arm_pkg::OFS_CTRL) begin
      rd_data = ctrl_reg;
    end else if (ra == arm_pkg::OFS_SIPA) begin
      rd_data = sip_addr_reg;
    end else if (ra == arm_pkg::OFS_SIPM) begin
      rd_data = sip_mask_reg;
    end else if (ra == arm_pkg::OFS_TIPA) begin
      rd_data = tip_addr_reg;
    end else if (ra == arm_pkg::OFS_TIPM) begin
      rd_data = tip_mask_reg;
    end else if (ra == arm_pkg::OFS_STAT) begin
      rd_data = {30'h00000000, seen_reg, last_hit_reg};
    end else if (ra == arm_pkg::OFS_COUNT) begin
      rd_data = hit_cnt_reg;
    end else begin
      rd_data   = 32'h00000000;
      rd_mapped = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= arm_pkg::RESP_OK;
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      awaddr_reg  <= '0;
      wdata_reg   <= 32'h00000000;
      wstrb_reg   <= 4'h0;
    end else begin
      awready_reg <= ~aw_held_next & ~bvalid_next;
      wready_reg  <= ~w_held_next & ~bvalid_next;
      aw_held_reg <= aw_held_next;
      w_held_reg  <= w_held_next;
      bvalid_reg  <= bvalid_next;
      if (aw_hs) begin
        awaddr_reg <= s_axi_awaddr;
      end
      if (w_hs) begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        bresp_reg <= wr_mapped ? arm_pkg::RESP_OK : arm_pkg::RESP_DEC;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h00000000;
      rresp_reg   <= arm_pkg::RESP_OK;
    end else begin
      arready_reg <= ~rvalid_next;
      rvalid_reg  <= rvalid_next;
      if (ar_hs) begin
        rdata_reg <= rd_data;
        rresp_reg <= rd_mapped ? arm_pkg::RESP_OK : arm_pkg::RESP_DEC;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg     <= arm_pkg::CTRL_RST;
      sip_addr_reg <= arm_pkg::ADDR_RST;
      sip_mask_reg <= arm_pkg::MASK_RST;
      tip_addr_reg <= arm_pkg::ADDR_RST;
      tip_mask_reg <= arm_pkg::MASK_RST;
    end else begin
      if (wr_ctrl) ctrl_reg <= merge(ctrl_reg, wdata_reg, wstrb_reg);
      if (wr_sipa) sip_addr_reg <= merge(sip_addr_reg, wdata_reg, wstrb_reg);
      if (wr_sipm) sip_mask_reg <= merge(sip_mask_reg, wdata_reg, wstrb_reg);
      if (wr_tipa) tip_addr_reg <= merge(tip_addr_reg, wdata_reg, wstrb_reg);
      if (wr_tipm) tip_mask_reg <= merge(tip_mask_reg, wdata_reg, wstrb_reg);
    end
  end

  // Criteria
  arm_ip_if sip_if ();
  arm_ip_if tip_if ();

  assign sip_if.mode     = arm_pkg::arm_ipm_e'(ctrl_reg[arm_pkg::F_SIP+:2]);
  assign sip_if.cfg_addr = sip_addr_reg;
  assign sip_if.cfg_mask = sip_mask_reg;
  assign sip_if.frm_addr = frm_spa;
  assign tip_if.mode     = arm_pkg::arm_ipm_e'(ctrl_reg[arm_pkg::F_TIP+:2]);
  assign tip_if.cfg_addr = tip_addr_reg;
  assign tip_if.cfg_mask = tip_mask_reg;
  assign tip_if.frm_addr = frm_tpa;

  arm_ip_crit u_sip (.ipc(sip_if.crit));
  arm_ip_crit u_tip (.ipc(tip_if.crit));

  wire logic sha_ok;
  wire logic tha_ok;
  wire logic len_ok;
  wire logic hrd_ok;
  wire logic pro_ok;
  wire logic all_ok;
  wire logic rule_en;

  // Sender hardware match applies to ARP frames only, target hardware match to RARP only
  arm_tri_crit u_sha (.sel(ctrl_reg[arm_pkg::F_SHA+:2]), .applies(~frm_rarp),
                      .cond(frm_sha == frame_source_mac), .ok(sha_ok));
  arm_tri_crit u_tha (.sel(ctrl_reg[arm_pkg::F_THA+:2]), .applies(frm_rarp),
                      .cond(frm_tha == frame_source_mac), .ok(tha_ok));
  arm_tri_crit u_len (.sel(ctrl_reg[arm_pkg::F_LEN+:2]), .applies(1'b1),
                      .cond((frm_hln == arm_pkg::HLN_ETH) & (frm_pln == arm_pkg::PLN_IPV4)),
                      .ok(len_ok));
  arm_tri_crit u_hrd (.sel(ctrl_reg[arm_pkg::F_HRD+:2]), .applies(1'b1),
                      .cond(frm_hrd == arm_pkg::HRD_ETH), .ok(hrd_ok));
  arm_tri_crit u_pro (.sel(ctrl_reg[arm_pkg::F_PRO+:2]), .applies(1'b1),
                      .cond(frm_pro == arm_pkg::PRO_IP), .ok(pro_ok));

  assign rule_en = ctrl_reg[arm_pkg::F_EN];
  assign all_ok  = sip_if.ok & tip_if.ok & sha_ok & tha_ok & len_ok & hrd_ok & pro_ok;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hit_valid_reg <= 1'b0;
      hit_reg       <= 1'b0;
      last_hit_reg  <= 1'b0;
      seen_reg      <= 1'b0;
      hit_cnt_reg   <= arm_pkg::CNT_RST;
    end else begin
      hit_valid_reg <= frm_valid;
      hit_reg       <= frm_valid & rule_en & all_ok;
      if (frm_valid) begin
        last_hit_reg <= rule_en & all_ok;
        seen_reg     <= 1'b1;
      end
      // A hit in the clearing cycle still counts
      if (wr_cnt) begin
        hit_cnt_reg <= {31'h00000000, hit_reg};
      end else if (hit_reg) begin
        hit_cnt_reg <= hit_cnt_reg + 32'h00000001;
      end
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign hit_valid     = hit_valid_reg;
  assign hit           = hit_reg;

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  wire logic frm_on = frm_valid & rule_en;
  wire logic sip_host = ctrl_reg[arm_pkg::F_SIP+:2] == 2'h1;
  wire logic sip_net  = ctrl_reg[arm_pkg::F_SIP+:2] == 2'h2;
  wire logic tip_any  = ctrl_reg[arm_pkg::F_TIP+:2] == 2'h0;
  wire logic tip_host = ctrl_reg[arm_pkg::F_TIP+:2] == 2'h1;
  wire logic tip_net  = ctrl_reg[arm_pkg::F_TIP+:2] == 2'h2;
  wire logic all_any  = ctrl_reg[15:2] == 14'h2aa0;

  sequence s_miss;
    hit_valid_reg && !hit_reg;
  endsequence

  property p_sip_host;
    frm_on && sip_host && (frm_spa != sip_addr_reg) |=> s_miss;
  endproperty
  a_sip_host: assert property (p_sip_host) else $error("sender host mismatch hit");

  property p_sip_net;
    frm_on && sip_net && (((frm_spa ^ sip_addr_reg) & sip_mask_reg) != 32'h0) |=> s_miss;
  endproperty
  a_sip_net: assert property (p_sip_net) else $error("sender network mismatch hit");

  property p_tip_any;
    frm_on && tip_any && sip_if.ok && sha_ok && tha_ok && len_ok && hrd_ok && pro_ok |=> hit_reg;
  endproperty
  a_tip_any: assert property (p_tip_any) else $error("target any blocked hit");

  property p_tip_host;
    frm_on && tip_host && (frm_tpa != tip_addr_reg) |=> s_miss;
  endproperty
  a_tip_host: assert property (p_tip_host) else $error("target host mismatch hit");

  property p_tip_net;
    frm_on && tip_net && (((frm_tpa ^ tip_addr_reg) & tip_mask_reg) != 32'h0) |=> s_miss;
  endproperty
  a_tip_net: assert property (p_tip_net) else $error("target network mismatch hit");

  property p_sha;
    frm_on && !frm_rarp && (ctrl_reg[arm_pkg::F_SHA+:2] == 2'h0) && (frm_sha == frame_source_mac)
      |=> s_miss;
  endproperty
  a_sha: assert property (p_sha) else $error("sender hw zero setting hit equal");

  property p_tha;
    frm_on && frm_rarp && (ctrl_reg[arm_pkg::F_THA+:2] == 2'h1) && (frm_tha != frame_source_mac)
      |=> s_miss;
  endproperty
  a_tha: assert property (p_tha) else $error("target hw one setting hit differing");

  property p_len;
    frm_on && (ctrl_reg[arm_pkg::F_LEN+:2] == 2'h1) && ((frm_hln != 8'h06) || (frm_pln != 8'h04))
      |=> s_miss;
  endproperty
  a_len: assert property (p_len) else $error("length check passed bad lengths");

  property p_hrd;
    frm_on && (ctrl_reg[arm_pkg::F_HRD+:2] == 2'h0) && (frm_hrd == 16'h0001) |=> s_miss;
  endproperty
  a_hrd: assert property (p_hrd) else $error("hw space zero setting hit ethernet");

  property p_pro;
    frm_on && (ctrl_reg[arm_pkg::F_PRO+:2] == 2'h1) && (frm_pro != 16'h0800) |=> s_miss;
  endproperty
  a_pro: assert property (p_pro) else $error("protocol space check passed non ip");

  property p_all_any;
    frm_on && all_any |=> hit_valid_reg && hit_reg;
  endproperty
  a_all_any: assert property (p_all_any) else $error("all any settings missed");

  property p_and;
    hit_reg |-> $past(frm_valid) && $past(all_ok) && $past(rule_en);
  endproperty
  a_and: assert property (p_and) else $error("hit without every criterion");

  sequence s_both_held;
    aw_held_reg && w_held_reg && !bvalid_reg;
  endsequence

  property p_bresp;
    s_both_held |=> s_axi_bvalid ##1 (s_axi_bvalid || $past(s_axi_bready));
  endproperty
  a_bresp: assert property (p_bresp) else $error("write response dropped early");
endmodule // arm_top
`default_nettype wire

// file: verification/arm_frm_src.sv
// Ingress parser model: presents one ARP or RARP frame per call.
// Assumes send is entered just after a rising aclk edge.
`timescale 1ns/100ps
`default_nettype none
module arm_frm_src (
  input  wire logic        aclk,
  output logic             frm_valid,
  output logic             frm_rarp,
  output logic [47:0]      frame_source_mac,
  output logic [47:0]      frm_sha,
  output logic [47:0]      frm_tha,
  output logic [31:0]      frm_spa,
  output logic [31:0]      frm_tpa,
  output logic [15:0]      frm_hrd,
  output logic [15:0]      frm_pro,
  output logic [7:0]       frm_hln,
  output logic [7:0]       frm_pln
);
  localparam logic [47:0] MAC = 48'h02a0b1c2d3e4;

  initial begin
    frm_valid = 1'b0;
    {frm_rarp, frame_source_mac, frm_sha, frm_tha, frm_spa, frm_tpa, frm_hrd, frm_pro, frm_hln, frm_pln} = '0;
  end

  // Good frame with one field replaced; code 4 also marks the frame RARP
  task automatic send(input int f, input logic [47:0] v);
    frm_valid        <= 1'b1;
    frm_rarp         <= (f == 4) | ((f == 5) & v[0]);
    frame_source_mac <= MAC;
    frm_sha          <= (f == 3) ? v : MAC;
    frm_tha          <= (f == 4) ? v : MAC;
    frm_spa          <= (f == 1) ? v[31:0] : 32'h0a000001;
    frm_tpa          <= (f == 2) ? v[31:0] : 32'h0a000002;
    frm_hrd          <= (f == 6) ? v[15:0] : 16'h0001;
    frm_pro          <= (f == 7) ? v[15:0] : 16'h0800;
    frm_hln          <= 8'h06;
    frm_pln          <= (f == 8) ? v[7:0] : 8'h04;
    @(posedge aclk);
    frm_valid <= 1'b0;
    // Released fields other than frame_source_mac must not keep the old frame
    {frm_rarp, frm_sha, frm_tha, frm_spa, frm_tpa, frm_hrd, frm_pro, frm_hln, frm_pln} <=
      ~{frm_rarp, frm_sha, frm_tha, frm_spa, frm_tpa, frm_hrd, frm_pro, frm_hln, frm_pln};
  endtask
endmodule // arm_frm_src
`default_nettype wire

// file: verification/arm_top_tb.sv
// Self-checking bench for the ARP rule matcher over AXI4-Lite.
// Assumes arm_pkg, arm_ip_if, the rtl files and arm_frm_src compiled first.
`timescale 1ns/100ps
`default_nettype none
module arm_top_tb;
  logic        aclk;
  logic        aresetn;
  logic [7:0]  s_axi_awaddr;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic [7:0]  s_axi_araddr;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  logic        frm_valid;
  logic        frm_rarp;
  logic [47:0] frame_source_mac;
  logic [47:0] frm_sha;
  logic [47:0] frm_tha;
  logic [31:0] frm_spa;
  logic [31:0] frm_tpa;
  logic [15:0] frm_hrd;
  logic [15:0] frm_pro;
  logic [7:0]  frm_hln;
  logic [7:0]  frm_pln;
  logic        hit_valid;
  logic        hit;
  logic [15:0] ctrl_now;
  int          err_total;
  int          checks;
  int          nhit;

  arm_top arm_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .frm_valid, .frm_rarp, .frame_source_mac, .frm_sha, .frm_tha, .frm_spa,
    .frm_tpa, .frm_hrd, .frm_pro, .frm_hln, .frm_pln, .hit_valid, .hit);

  arm_frm_src arm_frm_src_inst (.aclk, .frm_valid, .frm_rarp, .frame_source_mac, .frm_sha, .frm_tha,
    .frm_spa, .frm_tpa, .frm_hrd, .frm_pro, .frm_hln, .frm_pln);

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic tmo(input int n);
    if (n >= 64) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, n, 64);
      wrap_up();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    tmo(n);
    chk(s_axi_bresp, er);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    tmo(n);
    chk(s_axi_rdata, ed);
    chk(s_axi_rresp, er);
  endtask

  // Frames under one setting run with one idle cycle between them
  task automatic tc(input logic [15:0] c, input int f, input logic [47:0] v, input logic e);
    if (c !== ctrl_now) wr(arm_pkg::OFS_CTRL, {16'h0000, c}, arm_pkg::RESP_OK);
    ctrl_now = c;
    arm_frm_src_inst.send(f, v);
    @(posedge aclk);
    chk(hit_valid, 1'b1);
    chk(hit, e);
    if (e) nhit++;
  endtask

  initial begin
    aresetn       = 1'b0;
    s_axi_awaddr  = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata   = 32'h0;
    s_axi_wvalid  = 1'b0;
    s_axi_bready  = 1'b0;
    s_axi_araddr  = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready  = 1'b0;
    ctrl_now      = 16'haa80;
    err_total     = 0;
    checks        = 0;
    nhit          = 0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(arm_pkg::OFS_CTRL, arm_pkg::CTRL_RST, arm_pkg::RESP_OK);
    rd(arm_pkg::OFS_TIPM, arm_pkg::MASK_RST, arm_pkg::RESP_OK);
    rd(arm_pkg::OFS_COUNT, arm_pkg::CNT_RST, arm_pkg::RESP_OK);
    rd(8'h1c, 32'h0, arm_pkg::RESP_DEC);
    wr(8'h1c, 32'h1, arm_pkg::RESP_DEC);
    wr(arm_pkg::OFS_SIPA, 32'h0a000001, arm_pkg::RESP_OK);
    wr(arm_pkg::OFS_SIPM, 32'hffffff00, arm_pkg::RESP_OK);
    wr(arm_pkg::OFS_TIPA, 32'h0a000002, arm_pkg::RESP_OK);
    wr(arm_pkg::OFS_TIPM, 32'hffff0000, arm_pkg::RESP_OK);
    rd(arm_pkg::OFS_SIPM, 32'hffffff00, arm_pkg::RESP_OK);
    tc(16'haa80, 0, 48'h0, 1'b0);
    tc(16'haa81, 8, 48'h5, 1'b1);
    tc(16'haa81, 2, 48'h0, 1'b1);
    tc(16'haa85, 0, 48'h0, 1'b1);
    tc(16'haa85, 1, 48'h0a000003, 1'b0);
    tc(16'haa89, 1, 48'h0a0000ff, 1'b1);
    tc(16'haa89, 1, 48'h0a000101, 1'b0);
    tc(16'haa91, 2, 48'h0a000003, 1'b0);
    tc(16'haa91, 0, 48'h0, 1'b1);
    tc(16'haaa1, 2, 48'h0a00abcd, 1'b1);
    tc(16'haaa1, 2, 48'h0a02ffff, 1'b0);
    tc(16'haa41, 0, 48'h0, 1'b1);
    tc(16'haa41, 3, 48'h1, 1'b0);
    tc(16'haa01, 3, 48'h1, 1'b1);
    tc(16'haa01, 0, 48'h0, 1'b0);
    tc(16'ha981, 5, 48'h1, 1'b1);
    tc(16'ha981, 4, 48'h1, 1'b0);
    tc(16'ha881, 4, 48'h1, 1'b1);
    tc(16'ha881, 5, 48'h1, 1'b0);
    tc(16'ha681, 0, 48'h0, 1'b1);
    tc(16'ha681, 8, 48'h5, 1'b0);
    tc(16'ha281, 8, 48'h5, 1'b1);
    tc(16'ha281, 0, 48'h0, 1'b0);
    tc(16'h9a81, 0, 48'h0, 1'b1);
    tc(16'h9a81, 6, 48'h6, 1'b0);
    tc(16'h8a81, 6, 48'h6, 1'b1);
    tc(16'h6a81, 0, 48'h0, 1'b1);
    tc(16'h6a81, 7, 48'h86dd, 1'b0);
    tc(16'h2a81, 7, 48'h86dd, 1'b1);
    tc(16'ha685, 1, 48'h0a000003, 1'b0);
    tc(16'ha685, 8, 48'h5, 1'b0);
    tc(16'ha685, 0, 48'h0, 1'b1);
    @(posedge aclk);
    chk(hit_valid, 1'b0);
    rd(arm_pkg::OFS_COUNT, 32'(nhit), arm_pkg::RESP_OK);
    rd(arm_pkg::OFS_STAT, 32'h00000003, arm_pkg::RESP_OK);
    wr(arm_pkg::OFS_COUNT, 32'h00000000, arm_pkg::RESP_OK);
    rd(arm_pkg::OFS_COUNT, arm_pkg::CNT_RST, arm_pkg::RESP_OK);
    wrap_up();
  end
endmodule // arm_top_tb
`default_nettype wire
